// ---- mcs_channel_select.sv ----
// Function
// - Control reserved bits read zero, ignore writes
// - Wide bit chooses 32 channel scheme or 128 channel scheme limited to blocks 0 and 1
// - Receive odd block field picks odd subframe
// - Receive even block field picks even subframe
// - Current block shows subframe being received
// - Multichannel off receives all; on selects
// - Receive enable register covers 32 channels
// - Receive upper half enables odd subframe channels
// - Receive lower half enables even subframe channels
// - Transmit enable register covers 32 channels
// - Transmit upper half enables odd subframe channels
// - Transmit lower half enables even subframe channels
// - Transmit odd block field picks odd subframe
// - Transmit even block field picks even subframe
// - Transmit mode field governs enabling and masking
`timescale 1ns/1ns
module mcs_channel_select #(
   parameter int WORD_W     = 32,
   parameter int FIFO_DEPTH = mcs_pkg::FIFO_DEPTH
)(
   input  wire logic              i_clock,
   input  wire logic              i_reset,
   // Avalon-MM slave
   input  wire logic [3:0]        i_avs_address,
   input  wire logic              i_avs_read,
   input  wire logic              i_avs_write,
   input  wire logic [31:0]       i_avs_writedata,
   input  wire logic [3:0]        i_avs_byteenable,
   output logic      [31:0]       o_avs_readdata,
   output logic                   o_avs_waitrequest,
   // Received words from the shifter
   input  wire logic              i_rx_word_valid,
   input  wire logic              i_rx_frame_start,
   input  wire logic [WORD_W-1:0] i_rx_word,
   output logic                   o_rx_word_ready,
   // Selected received words toward the user
   output logic                   o_rx_out_valid,
   output logic [WORD_W-1:0]      o_rx_out_word,
   input  wire logic              i_rx_out_ready,
   // Transmit slot decisions
   input  wire logic              i_tx_slot_valid,
   input  wire logic              i_tx_frame_start,
   output logic                   o_tx_chan_enable,
   output logic                   o_tx_drive,
   output logic                   o_tx_decision_valid,
   output logic [2:0]             o_rx_current_block,
   output logic [2:0]             o_tx_current_block
);

   // ********************
   // Selection helper
   // ********************

   // Decides whether a channel is picked by one pair of block fields and
   // one 32-bit enable word. Block k holds channels 16k to 16k+15, so an
   // even block k matches the even field when k/2 equals it, likewise odd.
   function automatic logic chan_picked(
      input logic [mcs_pkg::CHAN_W-1:0] idx,
      input logic [1:0]                 even_sel,
      input logic [1:0]                 odd_sel,
      input logic [31:0]                enables,
      input logic                       wide
   );
      logic [2:0] blk;
      logic [3:0] pos;
      logic       hit;
      blk = idx[6:4];
      pos = idx[3:0];
      hit = 1'b0;
      if (wide)
      begin
         // Only blocks 0 and 1 have enable bits here; the extended
         // enable bank for blocks 2 to 7 is not part of this block
         if (blk == 3'h0)
         begin
            hit = enables[pos];
         end
         else if (blk == 3'h1)
         begin
            hit = enables[mcs_pkg::ODD_EN_LSB + int'(pos)];
         end
      end
      else if (!blk[0])
      begin
         hit = (blk[2:1] == even_sel) && enables[pos];
      end
      else
      begin
         hit = (blk[2:1] == odd_sel)
               && enables[mcs_pkg::ODD_EN_LSB + int'(pos)];
      end
      return hit;
   endfunction

   // ********************
   // Registers
   // ********************
   logic [31:0]                control_reg;
   logic [31:0]                rx_enable_reg;
   logic [31:0]                tx_enable_reg;
   logic [31:0]                wmask;
   logic [31:0]                control_view;
   logic                       bus_ack_reg;
   logic [31:0]                readdata_reg;
   logic                       bus_req;
   logic                       bus_write_now;

   // Control fields
   logic                       rx_on;
   logic                       rx_wide;
   logic                       tx_wide;
   logic [1:0]                 rx_even_sel;
   logic [1:0]                 rx_odd_sel;
   logic [1:0]                 tx_even_sel;
   logic [1:0]                 tx_odd_sel;
   mcs_pkg::mcs_tx_mode_t      tx_mode;

   assign rx_on       = control_reg[mcs_pkg::RX_ON_BIT];
   assign rx_wide     = control_reg[mcs_pkg::RX_WIDE_BIT];
   assign tx_wide     = control_reg[mcs_pkg::TX_WIDE_BIT];
   assign rx_even_sel = control_reg[mcs_pkg::RX_EVEN_LSB +: 2];
   assign rx_odd_sel  = control_reg[mcs_pkg::RX_ODD_LSB +: 2];
   assign tx_even_sel = control_reg[mcs_pkg::TX_EVEN_LSB +: 2];
   assign tx_odd_sel  = control_reg[mcs_pkg::TX_ODD_LSB +: 2];
   assign tx_mode     = mcs_pkg::mcs_tx_mode_t'(control_reg[mcs_pkg::TX_MODE_LSB +: 2]);

   // ********************
   // Avalon-MM slave
   // ********************

   // Every access takes one wait cycle: the first edge latches read data,
   // the second edge completes the transfer. Costs a cycle, keeps readdata
   // a plain flop output.
   assign bus_req           = i_avs_read | i_avs_write;
   assign o_avs_waitrequest = bus_req & ~bus_ack_reg;
   assign o_avs_readdata    = readdata_reg;
   assign bus_write_now     = i_avs_write & bus_ack_reg;

   genvar lane;
   generate
      for (lane = 0; lane < 4; lane++)
      begin : g_lane
         assign wmask[lane*8 +: 8] = {8{i_avs_byteenable[lane]}};
      end
   endgenerate

   always_ff @(posedge i_clock)
   begin
      if (i_reset)
      begin
         bus_ack_reg <= 1'b0;
      end
      else
      begin
         bus_ack_reg <= bus_req & ~bus_ack_reg;
      end
   end

   logic [2:0] rx_cur_blk_reg;
   logic [2:0] tx_cur_blk_reg;

   // Live block counters are merged into the read view only
   always_comb
   begin
      control_view = control_reg & mcs_pkg::CONTROL_WRITE_MASK;
      control_view[mcs_pkg::RX_CUR_LSB +: 3] = rx_cur_blk_reg;
      control_view[mcs_pkg::TX_CUR_LSB +: 3] = tx_cur_blk_reg;
   end

   always_ff @(posedge i_clock)
   begin
      if (i_reset)
      begin
         readdata_reg <= 32'h0000_0000;
      end
      else if (i_avs_read & ~bus_ack_reg)
      begin
         case (i_avs_address)
            mcs_pkg::ADDR_MULTICHANNEL_CONTROL:    readdata_reg <= control_view;
            mcs_pkg::ADDR_RECEIVE_CHANNEL_ENABLE:  readdata_reg <= rx_enable_reg;
            mcs_pkg::ADDR_TRANSMIT_CHANNEL_ENABLE: readdata_reg <= tx_enable_reg;
            default:                               readdata_reg <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (i_reset)
      begin
         control_reg <= mcs_pkg::CONTROL_RESET;
      end
      else if (bus_write_now && i_avs_address == mcs_pkg::ADDR_MULTICHANNEL_CONTROL)
      begin
         // Reserved and live-status bits never take a written value
         control_reg <= (control_reg & ~(wmask & mcs_pkg::CONTROL_WRITE_MASK))
                        | (i_avs_writedata & wmask & mcs_pkg::CONTROL_WRITE_MASK);
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (i_reset)
      begin
         rx_enable_reg <= mcs_pkg::RX_ENABLE_RESET;
      end
      else if (bus_write_now && i_avs_address == mcs_pkg::ADDR_RECEIVE_CHANNEL_ENABLE)
      begin
         rx_enable_reg <= (rx_enable_reg & ~wmask) | (i_avs_writedata & wmask);
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (i_reset)
      begin
         tx_enable_reg <= mcs_pkg::TX_ENABLE_RESET;
      end
      else if (bus_write_now && i_avs_address == mcs_pkg::ADDR_TRANSMIT_CHANNEL_ENABLE)
      begin
         tx_enable_reg <= (tx_enable_reg & ~wmask) | (i_avs_writedata & wmask);
      end
   end

   // ********************
   // Receive channel tracking and selection
   // ********************
   localparam logic [mcs_pkg::CHAN_W-1:0] LAST_IDX = mcs_pkg::CHAN_W'(mcs_pkg::CHANNELS - 1);
   logic [mcs_pkg::CHAN_W-1:0] rx_next_idx_reg;
   logic [mcs_pkg::CHAN_W-1:0] rx_idx;
   logic                       rx_keep;
   logic                       rx_taken;
   logic                       fifo_fill_ready;

   mcs_stream_if #(.WIDTH(WORD_W)) rx_fill_if ();
   mcs_stream_if #(.WIDTH(WORD_W)) rx_drain_if ();

   // A frame start restarts numbering at channel 0
   assign rx_idx  = i_rx_frame_start ? '0 : rx_next_idx_reg;
   assign rx_keep = ~rx_on
                    | chan_picked(rx_idx, rx_even_sel, rx_odd_sel,
                                  rx_enable_reg, rx_wide);

   // Dropped words never wait on the FIFO; kept ones stall the shifter while it is full
   assign fifo_fill_ready  = rx_fill_if.ready;
   assign o_rx_word_ready  = ~rx_keep | fifo_fill_ready;
   assign rx_taken         = i_rx_word_valid & o_rx_word_ready;
   assign rx_fill_if.valid = i_rx_word_valid & rx_keep;
   assign rx_fill_if.data  = i_rx_word;

   always_ff @(posedge i_clock)
   begin
      if (i_reset)
      begin
         rx_next_idx_reg <= '0;
         rx_cur_blk_reg  <= 3'h0;
      end
      else if (rx_taken)
      begin
         // Saturate so over-long frames do not wrap into channel 0
         rx_next_idx_reg <= (rx_idx == LAST_IDX) ? rx_idx : rx_idx + 1'b1;
         rx_cur_blk_reg <= rx_idx[6:4];
      end
   end

   mcs_fifo #(
      .WIDTH (WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_rx_fifo (
      .i_clock (i_clock),
      .i_reset (i_reset),
      .fill    (rx_fill_if),
      .drain   (rx_drain_if)
   );

   assign o_rx_out_valid    = rx_drain_if.valid;
   assign o_rx_out_word     = rx_drain_if.data;
   assign rx_drain_if.ready = i_rx_out_ready;
   assign o_rx_current_block = rx_cur_blk_reg;

   // ********************
   // Transmit channel tracking and masking
   // ********************
   logic [mcs_pkg::CHAN_W-1:0] tx_next_idx_reg;
   logic [mcs_pkg::CHAN_W-1:0] tx_idx;
   logic                       tx_sel;
   logic                       tx_sym_sel;
   logic                       tx_sym_unmask;
   logic                       tx_enable_next;
   logic                       tx_drive_next;
   logic                       tx_enable_reg_q;
   logic                       tx_drive_reg;
   logic                       tx_valid_reg;

   assign tx_idx = i_tx_frame_start ? '0 : tx_next_idx_reg;
   assign tx_sel = chan_picked(tx_idx, tx_even_sel, tx_odd_sel,
                               tx_enable_reg, tx_wide);
   // Symmetric mode borrows the receive blocks and enables
   assign tx_sym_sel    = chan_picked(tx_idx, rx_even_sel, rx_odd_sel,
                                      rx_enable_reg, rx_wide);
   assign tx_sym_unmask = chan_picked(tx_idx, rx_even_sel, rx_odd_sel,
                                      tx_enable_reg, rx_wide);

   always_comb
   begin
      case (tx_mode)
         mcs_pkg::MCS_TX_ALL_DRIVEN:
            {tx_enable_next, tx_drive_next} = 2'b11;
         mcs_pkg::MCS_TX_SELECTED:
            {tx_enable_next, tx_drive_next} = {tx_sel, tx_sel};
         mcs_pkg::MCS_TX_MASKED:
            {tx_enable_next, tx_drive_next} = {1'b1, tx_sel};
         mcs_pkg::MCS_TX_SYMMETRIC:
            {tx_enable_next, tx_drive_next} = {tx_sym_sel, tx_sym_sel & tx_sym_unmask};
         default:
            {tx_enable_next, tx_drive_next} = 2'b00;
      endcase
   end

   always_ff @(posedge i_clock)
   begin
      if (i_reset)
      begin
         tx_next_idx_reg <= '0;
         tx_cur_blk_reg  <= 3'h0;
      end
      else if (i_tx_slot_valid)
      begin
         tx_next_idx_reg <= (tx_idx == LAST_IDX) ? tx_idx : tx_idx + 1'b1;
         tx_cur_blk_reg <= tx_idx[6:4];
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (i_reset)
      begin
         tx_enable_reg_q <= 1'b0;
         tx_drive_reg    <= 1'b0;
         tx_valid_reg    <= 1'b0;
      end
      else
      begin
         tx_valid_reg <= i_tx_slot_valid;
         if (i_tx_slot_valid)
         begin
            tx_enable_reg_q <= tx_enable_next;
            tx_drive_reg    <= tx_drive_next;
         end
      end
   end

   assign o_tx_chan_enable    = tx_enable_reg_q;
   assign o_tx_drive          = tx_drive_reg;
   assign o_tx_decision_valid = tx_valid_reg;
   assign o_tx_current_block  = tx_cur_blk_reg;

endmodule

// ---- mcs_pkg.sv ----
package mcs_pkg;

   // ********************
   // Register byte addresses
   // ********************
   localparam logic [3:0]  ADDR_MULTICHANNEL_CONTROL    = 4'h0;
   localparam logic [3:0]  ADDR_RECEIVE_CHANNEL_ENABLE  = 4'h4;
   localparam logic [3:0]  ADDR_TRANSMIT_CHANNEL_ENABLE = 4'h8;

   // ********************
   // Control register field positions
   // ********************
   localparam int RX_ON_BIT     = 0;
   localparam int RX_CUR_LSB    = 2;
   localparam int RX_EVEN_LSB   = 5;
   localparam int RX_ODD_LSB    = 7;
   localparam int RX_WIDE_BIT   = 9;
   localparam int TX_MODE_LSB   = 16;
   localparam int TX_CUR_LSB    = 18;
   localparam int TX_EVEN_LSB   = 21;
   localparam int TX_ODD_LSB    = 23;
   localparam int TX_WIDE_BIT   = 25;
   localparam int ODD_EN_LSB    = 16;

   // Bits that software may change; everything else except the live current-block fields reads as zero
   localparam logic [31:0] CONTROL_WRITE_MASK = 32'h03E3_03E1;

   // ********************
   // Reset values
   // ********************
   localparam logic [31:0] CONTROL_RESET  = 32'h0000_0000;
   localparam logic [31:0] RX_ENABLE_RESET = 32'h0000_0000;
   localparam logic [31:0] TX_ENABLE_RESET = 32'h0000_0000;

   // ********************
   // Frame geometry and modes
   // ********************
   localparam int CHANNELS       = 128;
   localparam int CHAN_W         = 7;
   localparam int FIFO_DEPTH     = 16;

   typedef enum logic [1:0]
   {
      MCS_TX_ALL_DRIVEN = 2'h0,
      MCS_TX_SELECTED   = 2'h1,
      MCS_TX_MASKED     = 2'h2,
      MCS_TX_SYMMETRIC  = 2'h3
   } mcs_tx_mode_t;

endpackage

// ---- mcs_stream_if.sv ----
`timescale 1ns/1ns
interface mcs_stream_if #(parameter int WIDTH = 32);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;

   modport source (output valid, output data, input ready);
   modport sink   (input valid, input data, output ready);
endinterface

// ---- mcs_fifo.sv ----
`timescale 1ns/1ns
module mcs_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
)(
   input  wire logic     i_clock,
   input  wire logic     i_reset,
   mcs_stream_if.sink    fill,
   mcs_stream_if.source  drain
);
   localparam int PTR_W = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PTR_W-1:0] wr_ptr_reg;
   logic [PTR_W-1:0] rd_ptr_reg;
   logic [PTR_W:0]   count_reg;
   logic             push;
   logic             pop;

   assign fill.ready  = (count_reg != (PTR_W+1)'(DEPTH));
   assign drain.valid = (count_reg != '0);
   assign drain.data  = mem_reg[rd_ptr_reg];
   assign push        = fill.valid & fill.ready;
   assign pop         = drain.valid & drain.ready;

   always_ff @(posedge i_clock)
   begin
      if (push)
      begin
         mem_reg[wr_ptr_reg] <= fill.data;
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (i_reset)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_reg <= (wr_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_reg <= (rd_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
         end
         if (push & ~pop)
         begin
            count_reg <= count_reg + 1'b1;
         end
         else if (pop & ~push)
         begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end
endmodule

// ---- mcs_channel_select_monitor.sv ----
`timescale 1ns/1ns
module mcs_channel_select_monitor #(
   parameter int WORD_W     = 32,
   parameter int FIFO_DEPTH = 16
)(
   input wire logic              i_clock,
   input wire logic              i_reset,
   input wire logic [3:0]        i_avs_address,
   input wire logic              i_avs_read,
   input wire logic              i_avs_write,
   input wire logic [31:0]       i_avs_writedata,
   input wire logic [3:0]        i_avs_byteenable,
   input wire logic [31:0]       o_avs_readdata,
   input wire logic              o_avs_waitrequest,
   input wire logic              i_rx_word_valid,
   input wire logic              i_rx_frame_start,
   input wire logic [WORD_W-1:0] i_rx_word,
   input wire logic              o_rx_word_ready,
   input wire logic              o_rx_out_valid,
   input wire logic [WORD_W-1:0] o_rx_out_word,
   input wire logic              i_rx_out_ready,
   input wire logic              i_tx_slot_valid,
   input wire logic              i_tx_frame_start,
   input wire logic              o_tx_chan_enable,
   input wire logic              o_tx_drive,
   input wire logic              o_tx_decision_valid,
   input wire logic [2:0]        o_rx_current_block,
   input wire logic [2:0]        o_tx_current_block
);
   // ********************
   // Shadow of frame position and control fields
   // ********************
   logic [6:0] rx_idx_reg;
   logic [6:0] tx_idx_reg;
   logic [1:0] mode_reg;
   logic       rx_on_reg;
   logic       rx_take;
   logic       ctl_wr;
   logic       ctl_rd;
   assign rx_take = i_rx_word_valid && o_rx_word_ready;
   assign ctl_wr  = i_avs_write && !o_avs_waitrequest && i_avs_address == 4'h0;
   assign ctl_rd  = i_avs_read && !o_avs_waitrequest && i_avs_address == 4'h0;
   always_ff @(posedge i_clock)
      if (i_reset)
         rx_idx_reg <= 7'h00;
      else if (rx_take)
         rx_idx_reg <= i_rx_frame_start ? 7'h00 : rx_idx_reg + {6'h00, rx_idx_reg != 7'h7F};
   always_ff @(posedge i_clock)
      if (i_reset)
         tx_idx_reg <= 7'h00;
      else if (i_tx_slot_valid)
         tx_idx_reg <= i_tx_frame_start ? 7'h00 : tx_idx_reg + {6'h00, tx_idx_reg != 7'h7F};
   always_ff @(posedge i_clock)
      if (i_reset)
         mode_reg <= 2'h0;
      else if (ctl_wr && i_avs_byteenable[2])
         mode_reg <= i_avs_writedata[17:16];
   always_ff @(posedge i_clock)
      if (i_reset)
         rx_on_reg <= 1'b0;
      else if (ctl_wr && i_avs_byteenable[0])
         rx_on_reg <= i_avs_writedata[0];
   // ********************
   // Assertions
   // ********************
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_reset);
   ctrl_reserved_a: assert property (
      ctl_rd |-> o_avs_readdata[15:10] == 6'h00 && !o_avs_readdata[1])
      else $error("reserved control bits read nonzero");
   cur_block_rd_a: assert property (
      ctl_rd |-> o_avs_readdata[4:2] == $past(o_rx_current_block)
         && o_avs_readdata[20:18] == $past(o_tx_current_block))
      else $error("current block readback wrong");
   rx_block_a: assert property (
      rx_take |=> o_rx_current_block == rx_idx_reg[6:4])
      else $error("receive current block wrong");
   tx_block_a: assert property (
      i_tx_slot_valid |=> o_tx_decision_valid && o_tx_current_block == tx_idx_reg[6:4])
      else $error("transmit decision or block wrong");
   rx_all_kept_a: assert property (
      rx_take && !rx_on_reg |=> o_rx_out_valid)
      else $error("word dropped with selection off");
   tx_all_a: assert property (
      o_tx_decision_valid && $past(mode_reg) == 2'h0 |-> o_tx_chan_enable && o_tx_drive)
      else $error("mode 0 channel not driven");
   tx_masked_a: assert property (
      o_tx_decision_valid && $past(mode_reg) == 2'h2 |-> o_tx_chan_enable)
      else $error("mode 2 channel not enabled");
   tx_select_a: assert property (
      o_tx_decision_valid && $past(mode_reg) == 2'h1 |-> o_tx_chan_enable == o_tx_drive)
      else $error("mode 1 enable and drive differ");
   bus_wait_a: assert property (
      $rose(i_avs_read || i_avs_write) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
      else $error("register access wait wrong");
   out_hold_a: assert property (
      o_rx_out_valid && !i_rx_out_ready |=> o_rx_out_valid && $stable(o_rx_out_word))
      else $error("buffer output dropped while stalled");
   cover property (rx_take && !i_rx_frame_start && rx_idx_reg == 7'h7E);
   cover property (i_rx_word_valid && !o_rx_word_ready);
   cover property (o_tx_decision_valid && $past(mode_reg) == 2'h3 && o_tx_drive);
endmodule

bind mcs_channel_select mcs_channel_select_monitor #(.WORD_W(WORD_W), .FIFO_DEPTH(FIFO_DEPTH))
   u_monitor (.*);

// ---- mcs_frame_source.sv ----
`timescale 1ns/1ns
module mcs_frame_source #(
   parameter logic [31:0] WORD_BASE = 32'hA500_0000
)(
   input  wire logic       i_clock,
   input  wire logic       i_reset,
   input  wire logic       i_start,
   input  wire logic [7:0] i_count,
   input  wire logic [3:0] i_gap,
   input  wire logic       i_ready,
   output logic            o_valid,
   output logic            o_frame_start,
   output logic [31:0]     o_word,
   output logic            o_busy
);
   initial
   begin
      o_valid = 1'b0;
      o_frame_start = 1'b0;
      o_word = 32'h0000_0000;
      o_busy = 1'b0;
      forever
      begin
         @(posedge i_clock);
         if (i_start && !i_reset)
         begin
            o_busy <= 1'b1;
            for (int k = 0; k < i_count; k++)
            begin
               o_valid <= 1'b1;
               o_frame_start <= (k == 0);
               o_word <= WORD_BASE + 32'(k);
               @(posedge i_clock);
               while (!i_ready)
                  @(posedge i_clock);
               if (i_gap != 4'h0 || k == i_count - 1)
               begin
                  o_valid <= 1'b0;
                  // A released line must not look like a held word
                  o_word <= ~o_word;
                  repeat (i_gap) @(posedge i_clock);
               end
            end
            o_busy <= 1'b0;
         end
      end
   end
endmodule

// ---- mcs_channel_select_tb.sv ----
`timescale 1ns/1ns
module mcs_channel_select_tb;
   localparam logic [31:0] BASE  = 32'hA500_0000;
   localparam int          LIMIT = 20000;
   logic        i_clock, i_reset, i_avs_read, i_avs_write, o_avs_waitrequest;
   logic        i_rx_word_valid, i_rx_frame_start, o_rx_word_ready, o_rx_out_valid;
   logic        i_rx_out_ready, i_tx_slot_valid, i_tx_frame_start, o_tx_chan_enable;
   logic        o_tx_drive, o_tx_decision_valid, src_start, src_busy;
   logic [3:0]  i_avs_address, i_avs_byteenable, src_gap;
   logic [31:0] i_avs_writedata, o_avs_readdata, i_rx_word, o_rx_out_word, rd_val;
   logic [2:0]  o_rx_current_block, o_tx_current_block;
   logic [7:0]  src_count;
   logic [31:0] exp_q[$];
   int          bad_count, n_checks, cycles;

   mcs_channel_select #(.WORD_W(32), .FIFO_DEPTH(16)) DUT (.*);
   mcs_frame_source #(.WORD_BASE(BASE)) u_source (
      .i_clock(i_clock), .i_reset(i_reset), .i_start(src_start), .i_count(src_count),
      .i_gap(src_gap), .i_ready(o_rx_word_ready), .o_valid(i_rx_word_valid),
      .o_frame_start(i_rx_frame_start), .o_word(i_rx_word), .o_busy(src_busy));

   // ********************
   // Checking and bus tasks
   // ********************
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(bit ok, string msg);
      n_checks++;
      if (!ok)
      begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask
   task automatic bus(bit wr, logic [3:0] a, logic [31:0] d, logic [3:0] be);
      @(posedge i_clock);
      i_avs_address <= a;
      i_avs_writedata <= d;
      i_avs_byteenable <= be;
      i_avs_read <= !wr;
      i_avs_write <= wr;
      @(posedge i_clock);
      while (o_avs_waitrequest !== 1'b0)
         @(posedge i_clock);
      rd_val = o_avs_readdata;
      i_avs_read <= 1'b0;
      i_avs_write <= 1'b0;
   endtask
   task automatic rd_chk(logic [3:0] a, logic [31:0] e, string msg);
      bus(1'b0, a, 32'h0000_0000, 4'hF);
      chk(rd_val === e, msg);
   endtask
   // Expected selection worked out from the block fields and enable halves
   function automatic bit sel(int ch, logic [1:0] ev, logic [1:0] od, logic w, logic [31:0] e);
      int b;
      b = ch / 16;
      if (w)
         return (b == 0) ? e[ch % 16] : (b == 1) ? e[16 + ch % 16] : 1'b0;
      if (b == 2 * ev)
         return e[ch % 16];
      if (b == 2 * od + 1)
         return e[16 + ch % 16];
      return 1'b0;
   endfunction

   always @(posedge i_clock)
      if (!i_reset && o_rx_out_valid === 1'b1 && i_rx_out_ready)
      begin
         chk(exp_q.size() != 0 && o_rx_out_word === exp_q[0], "received word");
         if (exp_q.size() != 0)
            void'(exp_q.pop_front());
      end
   always @(posedge i_clock)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         bad_count++;
         final_report();
      end
   end

   task automatic rx_frame(logic [31:0] c, logic [31:0] e, int n, int gap, bit stall);
      for (int ch = 0; ch < n; ch++)
         if (!c[0] || sel(ch, c[6:5], c[8:7], c[9], e))
            exp_q.push_back(BASE + 32'(ch));
      bus(1'b1, 4'h0, c, 4'hF);
      bus(1'b1, 4'h4, e, 4'hF);
      @(posedge i_clock);
      i_rx_out_ready <= !stall;
      src_count <= 8'(n);
      src_gap <= 4'(gap);
      src_start <= 1'b1;
      @(posedge i_clock);
      src_start <= 1'b0;
      if (stall)
      begin
         repeat (40) @(posedge i_clock);
         chk(o_rx_word_ready === 1'b0, "full buffer took a word");
         i_rx_out_ready <= 1'b1;
      end
      while (src_busy || exp_q.size() != 0)
         @(posedge i_clock);
      rd_chk(4'h0, c | 32'((n - 1) / 16) << 2, "receive current block");
      chk(o_rx_out_valid === 1'b0, "buffer not empty");
   endtask
   task automatic tx_frame(logic [31:0] c, logic [31:0] re, logic [31:0] xe);
      bit ts, rs, en, dr;
      for (int ch = 0; ch < 128; ch++)
      begin
         ts = sel(ch, c[22:21], c[24:23], c[25], xe);
         rs = sel(ch, c[6:5], c[8:7], c[9], re);
         case (c[17:16])
            2'h0: {en, dr} = 2'b11;
            2'h1: {en, dr} = {ts, ts};
            2'h2: {en, dr} = {1'b1, ts};
            default: {en, dr} = {rs, rs & sel(ch, c[6:5], c[8:7], c[9], xe)};
         endcase
         @(posedge i_clock);
         i_tx_slot_valid <= 1'b1;
         i_tx_frame_start <= (ch == 0);
         @(posedge i_clock);
         i_tx_slot_valid <= 1'b0;
         @(posedge i_clock);
         chk(o_tx_decision_valid === 1'b1 && o_tx_chan_enable === en && o_tx_drive === dr,
             "transmit decision");
      end
   endtask

   // ********************
   // Main sequence
   // ********************
   initial
   begin
      i_clock = 1'b0;
      forever #5 i_clock = ~i_clock;
   end
   initial
   begin
      logic [31:0] c;
      {i_reset, i_avs_read, i_avs_write, i_rx_out_ready, i_tx_slot_valid} = 5'b10000;
      {i_tx_frame_start, src_start, src_count, src_gap} = 14'h0000;
      {i_avs_address, i_avs_byteenable, i_avs_writedata} = 40'h00_0000_0000;
      repeat (16) @(posedge i_clock);
      i_reset <= 1'b0;
      rd_chk(4'h0, 32'h0000_0000, "control reset");
      rd_chk(4'h4, 32'h0000_0000, "receive enable reset");
      rd_chk(4'h8, 32'h0000_0000, "transmit enable reset");
      bus(1'b1, 4'hC, 32'hFFFF_FFFF, 4'hF);
      rd_chk(4'hC, 32'h0000_0000, "unmapped address");
      bus(1'b1, 4'h0, 32'hFFFF_FFFF, 4'hF);
      rd_chk(4'h0, 32'h03E3_03E1, "control writable bits");
      bus(1'b1, 4'h4, 32'hFFFF_FFFF, 4'hF);
      bus(1'b1, 4'h4, 32'h0000_0000, 4'h5);
      rd_chk(4'h4, 32'hFF00_FF00, "receive enable lanes");
      bus(1'b1, 4'h8, 32'h1234_5678, 4'hF);
      rd_chk(4'h8, 32'h1234_5678, "transmit enable");
      $display("test registers done");
      rx_frame(32'h0000_0000, 32'h0000_0000, 128, 0, 1'b1);
      $display("test receive all done");
      for (int v = 0; v < 4; v++)
         rx_frame(32'h1 | 32'(v) << 5 | 32'(3 - v) << 7, 32'h8001_C003, 128, v, 1'b0);
      rx_frame(32'h0000_0201, 32'h0F0F_F00F, 40, 1, 1'b0);
      $display("test receive select done");
      for (int m = 0; m < 4; m++)
      begin
         c = 32'h0120_0081 | 32'(m) << 16 | (m == 1 ? 32'h0200_0000 : 32'h0000_0000);
         bus(1'b1, 4'h0, c, 4'hF);
         bus(1'b1, 4'h4, 32'hF0F0_1234, 4'hF);
         bus(1'b1, 4'h8, 32'h00FF_0F0F, 4'hF);
         tx_frame(c, 32'hF0F0_1234, 32'h00FF_0F0F);
         rd_chk(4'h0, c | 32'h001C_0008, "transmit current block");
      end
      $display("test transmit modes done");
      final_report();
   end
endmodule
